// *** inc/ppc_pkg.sv ***
package ppc_pkg;
    // Register word indices (printed offsets are not multiples of four: indices, address = 4*index)
    localparam logic [15:0] PPC_IDX_P0_DIR  = 16'hff20;
    localparam logic [15:0] PPC_IDX_P1_DIR  = 16'hff21;
    localparam logic [15:0] PPC_IDX_P2_DIR  = 16'hff22;
    localparam logic [15:0] PPC_IDX_P3_DIR  = 16'hff23;
    localparam logic [15:0] PPC_IDX_P5_DIR  = 16'hff25;
    localparam logic [15:0] PPC_IDX_P8_DIR  = 16'hff28;
    localparam logic [15:0] PPC_IDX_P0_PUE  = 16'hff30;
    localparam logic [15:0] PPC_IDX_P1_PUE  = 16'hff31;
    localparam logic [15:0] PPC_IDX_P2_PUE  = 16'hff32;
    localparam logic [15:0] PPC_IDX_P3_PUE  = 16'hff33;
    // Own choices: segment selects and port data registers
    localparam logic [15:0] PPC_IDX_P7_SEG  = 16'hff57;
    localparam logic [15:0] PPC_IDX_P8_SEG  = 16'hff58;
    localparam logic [15:0] PPC_IDX_P0_DAT  = 16'hff00;
    localparam logic [15:0] PPC_IDX_P1_DAT  = 16'hff01;
    localparam logic [15:0] PPC_IDX_P2_DAT  = 16'hff02;
    localparam logic [15:0] PPC_IDX_P3_DAT  = 16'hff03;
    localparam logic [15:0] PPC_IDX_P5_DAT  = 16'hff05;
    localparam logic [15:0] PPC_IDX_P7_DAT  = 16'hff07;
    localparam logic [15:0] PPC_IDX_P8_DAT  = 16'hff08;
    // Implemented bit masks
    localparam logic [7:0]  PPC_MASK_P0     = 8'hff;
    localparam logic [7:0]  PPC_MASK_P1     = 8'h03;
    localparam logic [7:0]  PPC_MASK_P2     = 8'h3f;
    localparam logic [7:0]  PPC_MASK_P3     = 8'h1f;
    localparam logic [7:0]  PPC_MASK_P5     = 8'h0f;
    localparam logic [7:0]  PPC_MASK_P7     = 8'h0f;
    localparam logic [7:0]  PPC_MASK_P8     = 8'hff;
    // Reset values
    localparam logic [7:0]  PPC_DIR_RST     = 8'hff;
    localparam logic [7:0]  PPC_PUE_RST     = 8'h00;
    localparam logic [7:0]  PPC_SEG_RST     = 8'h00;
    localparam logic [7:0]  PPC_DAT_RST     = 8'h00;
    // Write modes
    localparam logic [1:0]  PPC_WM_BYTE     = 2'h0;
    localparam logic [1:0]  PPC_WM_SET      = 2'h1;
    localparam logic [1:0]  PPC_WM_CLR      = 2'h2;
    // Bit-write field: pwdata[10:8] = bit index, pwdata[13:12] = mode
    localparam int          PPC_BIT_LSB     = 8;
    localparam int          PPC_MODE_LSB    = 12;

    // Byte or single-bit update of a register
    function automatic logic [7:0] ppc_wr(input logic [7:0] cur, input logic [31:0] wd);
        logic [7:0] b;
        b = 8'h01 << wd[PPC_BIT_LSB +: 3];
        unique case (wd[PPC_MODE_LSB +: 2])
            PPC_WM_SET: ppc_wr = cur | b;
            PPC_WM_CLR: ppc_wr = cur & ~b;
            default:    ppc_wr = wd[7:0];
        endcase
    endfunction
endpackage

// *** logic/ppc_port_pin.sv ***
`timescale 1ns/1ps
// One port of up to 8 pins: latch, direction, pull-up, pin driver, read mux
module ppc_port_pin
    import ppc_pkg::*;
#(
    parameter logic [7:0] IMPL     = 8'hff,
    parameter logic [7:0] DIR_IMPL = 8'hff,
    parameter logic [7:0] PUE_IMPL = 8'h00
)(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Register writes
    input  wire logic        i_wr_dat,
    input  wire logic        i_wr_dir,
    input  wire logic        i_wr_pue,
    input  wire logic [31:0] i_wdata,
    // Port/segment select (1 = segment)
    input  wire logic [7:0]  i_seg,
    // Pins
    input  wire logic [7:0]  i_pin,
    output logic      [7:0]  o_pin,
    output logic      [7:0]  o_pin_oe,
    output logic      [7:0]  o_pullup,
    // Register views
    output logic      [7:0]  o_dat,
    output logic      [7:0]  o_dir,
    output logic      [7:0]  o_pue
);
    logic [7:0] latch_reg;
    logic [7:0] dir_reg;
    logic [7:0] pue_reg;
    logic [7:0] out_mode;

    // Output latch updates in any mode
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            latch_reg <= PPC_DAT_RST;
        else if (i_wr_dat)
            latch_reg <= ppc_wr(latch_reg, i_wdata) & IMPL;
    end

    // Direction: all ones at reset, unimplemented bits stuck at 1
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            dir_reg <= PPC_DIR_RST;
        else if (i_wr_dir)
            dir_reg <= ppc_wr(dir_reg, i_wdata) | ~DIR_IMPL;
    end

    // Pull-up enable: zero at reset, unimplemented bits stuck at 0
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            pue_reg <= PPC_PUE_RST;
        else if (i_wr_pue)
            pue_reg <= ppc_wr(pue_reg, i_wdata) & PUE_IMPL;
    end

    // 0 = output with buffer on, 1 = input; only port-function bits drive
    assign out_mode = ~dir_reg & DIR_IMPL & IMPL & ~i_seg;
    assign o_pin    = latch_reg & out_mode;
    assign o_pin_oe = out_mode;
    // Pull-up only for enabled input pins
    assign o_pullup = pue_reg & dir_reg & PUE_IMPL & ~i_seg;
    // Read: latch for outputs, pin for inputs; never disturbs latch
    assign o_dat    = ((latch_reg & out_mode) | (i_pin & ~out_mode & ~i_seg)) & IMPL;
    assign o_dir    = dir_reg;
    assign o_pue    = pue_reg;
endmodule

// *** logic/ppc_apb_slave.sv ***
`timescale 1ns/1ps
// APB decode: zero wait states, error on unmapped index
module ppc_apb_slave
    import ppc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // APB
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [17:0] i_paddr,
    output logic             o_pready,
    output logic             o_pslverr,
    // Decode
    output logic      [15:0] o_index,
    output logic             o_hit,
    output logic             o_wr,
    output logic             o_rd,
    input  wire logic        i_known
);
    // Word index from byte address
    assign o_index   = i_paddr[17:2];
    assign o_hit     = i_psel & i_penable;
    // Misaligned or unmapped writes are refused and leave every register alone
    assign o_wr      = o_hit & i_pwrite & i_known & ~i_paddr[1] & ~i_paddr[0];
    assign o_rd      = o_hit & ~i_pwrite;
    // Answer in the access phase at once
    assign o_pready  = i_psel & i_penable & i_rst_n;
    assign o_pslverr = o_hit & (~i_known | i_paddr[1] | i_paddr[0]);
endmodule

// *** logic/ppc_top.sv ***
`timescale 1ns/1ps
// Operation
// - Port 7: 4-bit input only, no driver
// - Port 7 input only when port selected
// - Port 8: 8-bit bidirectional with latch, direction
// - Port 8 direction acts only on port bits
// - Port 8 direction meaningful if any port bit
// - Reset puts port 8 in input mode
// - Reset loads all direction registers with ones
// - Direction 0 output, 1 input
// - Only existing direction bits; others read 1
// - Byte and single-bit register access
// - Port 3 bits 0-3 also feed interrupt detect
// - Pull-up only when enabled and input
// - Output mode keeps pull-up disconnected
// - Reset clears all pull-up enables
// - Pull-up bit 0 off, 1 on
// - Pull-up registers ports 0-3, others zero
// - Segment select 0 port, 1 segment; reset 0
// - Read: pin for inputs, latch for outputs
// - Write updates latch even in input mode
module ppc_top
    import ppc_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [17:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Pin inputs
    input  wire logic [7:0]  i_p0_pin,
    input  wire logic [7:0]  i_p1_pin,
    input  wire logic [7:0]  i_p2_pin,
    input  wire logic [7:0]  i_p3_pin,
    input  wire logic [7:0]  i_p5_pin,
    input  wire logic [3:0]  i_p7_pin,
    input  wire logic [7:0]  i_p8_pin,
    // Pin outputs and enables
    output logic      [7:0]  o_p0_pin,
    output logic      [7:0]  o_p0_oe,
    output logic      [7:0]  o_p1_pin,
    output logic      [7:0]  o_p1_oe,
    output logic      [7:0]  o_p2_pin,
    output logic      [7:0]  o_p2_oe,
    output logic      [7:0]  o_p3_pin,
    output logic      [7:0]  o_p3_oe,
    output logic      [7:0]  o_p5_pin,
    output logic      [7:0]  o_p5_oe,
    output logic      [7:0]  o_p8_pin,
    output logic      [7:0]  o_p8_oe,
    // Pull-up connects
    output logic      [7:0]  o_p0_pullup,
    output logic      [7:0]  o_p1_pullup,
    output logic      [7:0]  o_p2_pullup,
    output logic      [7:0]  o_p3_pullup,
    // Segment selects for segment driver
    output logic      [3:0]  o_port7_segment_select,
    output logic      [7:0]  o_port8_segment_select,
    // Port 3 bits 0-3 level to external interrupt detection
    output logic      [3:0]  o_p3_irq_level
);
    localparam int NPORT = 6;

    logic [15:0] index;
    logic        hit;
    logic        wr;
    logic        rd;
    logic        known;
    logic [3:0]  seg7_reg;
    logic [7:0]  seg7_next;
    logic [7:0]  seg8_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  rd_mux;
    logic [7:0]  p7_dat;

    logic [7:0]  pin_in   [NPORT];
    logic [7:0]  pin_out  [NPORT];
    logic [7:0]  pin_oe   [NPORT];
    logic [7:0]  pull     [NPORT];
    logic [7:0]  dat      [NPORT];
    logic [7:0]  dir      [NPORT];
    logic [7:0]  pue      [NPORT];
    logic [7:0]  seg      [NPORT];
    logic [15:0] dat_idx  [NPORT];
    logic [15:0] dir_idx  [NPORT];
    logic [15:0] pue_idx  [NPORT];

    // Per-port maps: ports 0,1,2,3,5,8
    localparam logic [7:0] IMPL_T [NPORT] = '{PPC_MASK_P0, PPC_MASK_P1, PPC_MASK_P2,
                                              PPC_MASK_P3, PPC_MASK_P5, PPC_MASK_P8};
    localparam logic [7:0] PUE_T  [NPORT] = '{PPC_MASK_P0, PPC_MASK_P1, PPC_MASK_P2,
                                              PPC_MASK_P3, 8'h00, 8'h00};

    assign pin_in  = '{i_p0_pin, i_p1_pin, i_p2_pin, i_p3_pin, i_p5_pin, i_p8_pin};
    assign seg     = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, seg8_reg};
    assign dat_idx = '{PPC_IDX_P0_DAT, PPC_IDX_P1_DAT, PPC_IDX_P2_DAT,
                       PPC_IDX_P3_DAT, PPC_IDX_P5_DAT, PPC_IDX_P8_DAT};
    assign dir_idx = '{PPC_IDX_P0_DIR, PPC_IDX_P1_DIR, PPC_IDX_P2_DIR,
                       PPC_IDX_P3_DIR, PPC_IDX_P5_DIR, PPC_IDX_P8_DIR};
    // Ports 5 and 8 have no pull-up register; zero index never decodes
    assign pue_idx = '{PPC_IDX_P0_PUE, PPC_IDX_P1_PUE, PPC_IDX_P2_PUE,
                       PPC_IDX_P3_PUE, 16'h0000, 16'h0000};

    // Bus front end
    ppc_apb_slave u_apb
    (
        .i_clock   (i_clock),
        .i_rst_n   (i_rst_n),
        .i_psel    (i_psel),
        .i_penable (i_penable),
        .i_pwrite  (i_pwrite),
        .i_paddr   (i_paddr),
        .o_pready  (o_pready),
        .o_pslverr (o_pslverr),
        .o_index   (index),
        .o_hit     (hit),
        .o_wr      (wr),
        .o_rd      (rd),
        .i_known   (known)
    );

    // Ports with latch, direction and optional pull-up
    for (genvar g = 0; g < NPORT; g++)
    begin : g_port
        ppc_port_pin #(
            .IMPL     (IMPL_T[g]),
            .DIR_IMPL (IMPL_T[g]),
            .PUE_IMPL (PUE_T[g])
        ) u_port
        (
            .i_clock  (i_clock),
            .i_rst_n  (i_rst_n),
            .i_wr_dat (wr && index == dat_idx[g]),
            .i_wr_dir (wr && index == dir_idx[g]),
            .i_wr_pue (wr && index == pue_idx[g] && pue_idx[g] != 16'h0000),
            .i_wdata  (i_pwdata),
            .i_seg    (seg[g]),
            .i_pin    (pin_in[g]),
            .o_pin    (pin_out[g]),
            .o_pin_oe (pin_oe[g]),
            .o_pullup (pull[g]),
            .o_dat    (dat[g]),
            .o_dir    (dir[g]),
            .o_pue    (pue[g])
        );
    end

    // Segment selects, reset to port function
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            seg7_reg <= PPC_SEG_RST[3:0];
            seg8_reg <= PPC_SEG_RST;
        end
        else if (wr && index == PPC_IDX_P7_SEG)
            seg7_reg <= seg7_next[3:0] & PPC_MASK_P7[3:0];
        else if (wr && index == PPC_IDX_P8_SEG)
            seg8_reg <= ppc_wr(seg8_reg, i_pwdata);
    end

    // Byte or bit update of the 4-bit port 7 select, widened for the shared helper
    assign seg7_next = ppc_wr({4'h0, seg7_reg}, i_pwdata);

    // Port 7: input only, no latch, zero for segment bits
    assign p7_dat = {4'h0, i_p7_pin & ~seg7_reg};

    // Address decode and read mux
    always_comb
    begin
        known  = 1'b0;
        rd_mux = 8'h00;
        if (index == PPC_IDX_P7_DAT)
        begin
            known  = 1'b1;
            rd_mux = p7_dat;
        end
        if (index == PPC_IDX_P7_SEG)
        begin
            known  = 1'b1;
            rd_mux = {4'h0, seg7_reg};
        end
        if (index == PPC_IDX_P8_SEG)
        begin
            known  = 1'b1;
            rd_mux = seg8_reg;
        end
        for (int k = 0; k < NPORT; k++)
        begin
            if (index == dat_idx[k])
            begin
                known  = 1'b1;
                rd_mux = dat[k];
            end
            if (index == dir_idx[k])
            begin
                known  = 1'b1;
                rd_mux = dir[k]; // unimplemented bits read 1
            end
            if (pue_idx[k] != 16'h0000 && index == pue_idx[k])
            begin
                known  = 1'b1;
                rd_mux = pue[k];
            end
        end
        // Refused misaligned reads return zero
        if (i_paddr[1:0] != 2'h0)
            rd_mux = 8'h00;
    end

    // Read data register, updated on reads only
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_n)
            rdata_reg <= 32'h0000_0000;
        else if (rd)
            rdata_reg <= {24'h00_0000, rd_mux};
    end

    // Zero-wait read: present mux value during access phase
    assign o_prdata = (hit && !i_pwrite) ? {24'h00_0000, rd_mux} : rdata_reg;

    // Pin outputs
    assign o_p0_pin    = pin_out[0];
    assign o_p0_oe     = pin_oe[0];
    assign o_p1_pin    = pin_out[1];
    assign o_p1_oe     = pin_oe[1];
    assign o_p2_pin    = pin_out[2];
    assign o_p2_oe     = pin_oe[2];
    assign o_p3_pin    = pin_out[3];
    assign o_p3_oe     = pin_oe[3];
    // Port 5 is open drain: drive only low
    assign o_p5_pin    = 8'h00;
    assign o_p5_oe     = pin_oe[4] & ~pin_out[4];
    assign o_p8_pin    = pin_out[5];
    assign o_p8_oe     = pin_oe[5];
    assign o_p0_pullup = pull[0];
    assign o_p1_pullup = pull[1];
    assign o_p2_pullup = pull[2];
    assign o_p3_pullup = pull[3];
    assign o_port7_segment_select = seg7_reg;
    assign o_port8_segment_select = seg8_reg;

    // Driven level on port 3 bits 0-3 reaches interrupt detect
    assign o_p3_irq_level = (pin_oe[3][3:0] & pin_out[3][3:0]) |
                            (~pin_oe[3][3:0] & i_p3_pin[3:0]);
endmodule

// *** bench/ppc_top_props.sv ***
`timescale 1ns/1ps
// Port-level checks on the top module
module ppc_top_props
    import ppc_pkg::*;
(
    // Clock, reset and bus
    input wire logic        i_clock,
    input wire logic        i_rst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Pin enables and pull-ups
    input wire logic [7:0]  o_p0_oe,
    input wire logic [7:0]  o_p1_oe,
    input wire logic [7:0]  o_p2_oe,
    input wire logic [7:0]  o_p3_oe,
    input wire logic [7:0]  o_p5_oe,
    input wire logic [7:0]  o_p8_oe,
    input wire logic [7:0]  o_p0_pullup,
    input wire logic [7:0]  o_p1_pullup,
    input wire logic [7:0]  o_p2_pullup,
    input wire logic [7:0]  o_p3_pullup,
    input wire logic [7:0]  o_port8_segment_select
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Taken byte writes to the port 8 direction and port 0 pull-up registers
    sequence s_p8_dir_wr;
        i_psel && i_penable && i_pwrite && i_paddr == {PPC_IDX_P8_DIR, 2'h0}
            && i_pwdata[13:12] == PPC_WM_BYTE;
    endsequence
    sequence s_pue0_wr;
        i_psel && i_penable && i_pwrite && i_paddr == {PPC_IDX_P0_PUE, 2'h0}
            && i_pwdata[13:12] == PPC_WM_BYTE;
    endsequence
    a_zero_wait: assert property (i_psel && i_penable |-> o_pready)
        else $error("pready missing in access phase");
    a_misalign_err: assert property (i_psel && i_penable && i_paddr[1:0] != 2'h0 |-> o_pslverr)
        else $error("misaligned access not refused");
    a_p8_dir_out: assert property (s_p8_dir_wr |=>
        o_p8_oe == (~$past(i_pwdata[7:0]) & ~o_port8_segment_select))
        else $error("port 8 enables do not follow direction");
    a_pue_connect: assert property (s_pue0_wr |=>
        o_p0_pullup == ($past(i_pwdata[7:0]) & ~o_p0_oe))
        else $error("port 0 pull-ups do not follow enable");
    a_seg_no_drive: assert property ((o_p8_oe & o_port8_segment_select) == 8'h00)
        else $error("segment bit driven by port");
    a_out_no_pull: assert property ((o_p0_pullup & o_p0_oe) == 8'h00
        && (o_p1_pullup & o_p1_oe) == 8'h00 && (o_p2_pullup & o_p2_oe) == 8'h00
        && (o_p3_pullup & o_p3_oe) == 8'h00)
        else $error("pull-up on output pin");
    a_unimpl_idle: assert property (o_p1_oe[7:2] == 6'h00 && o_p2_oe[7:6] == 2'h0
        && o_p3_oe[7:5] == 3'h0 && o_p5_oe[7:4] == 4'h0)
        else $error("missing pin driven");
    a_reset_input: assert property (disable iff (1'b0) !i_rst_n |=>
        o_p8_oe == 8'h00 && o_p0_oe == 8'h00 && o_p0_pullup == 8'h00)
        else $error("reset did not release pins");
endmodule

bind ppc_top ppc_top_props u_props (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_p0_oe(o_p0_oe), .o_p1_oe(o_p1_oe), .o_p2_oe(o_p2_oe),
    .o_p3_oe(o_p3_oe), .o_p5_oe(o_p5_oe), .o_p8_oe(o_p8_oe), .o_p0_pullup(o_p0_pullup),
    .o_p1_pullup(o_p1_pullup), .o_p2_pullup(o_p2_pullup), .o_p3_pullup(o_p3_pullup),
    .o_port8_segment_select(o_port8_segment_select));

// *** bench/ppc_pin_model.sv ***
`timescale 1ns/1ps
// Package pins of one port seen from the board
module ppc_pin_model (
    // Board level on lines nobody drives
    input  wire logic [7:0] i_ext,
    // Device side
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pull,
    // Resolved line level
    output logic      [7:0] o_level
);
    // Driver wins, then the pull-up, else the board level
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            o_level[i] = i_oe[i] ? i_out[i] : (i_pull[i] ? 1'b1 : i_ext[i]);
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for the port control block
module tb_top
    import ppc_pkg::*;
;
    logic        clk, rst_n, psel, penable, pwrite, pready, er, erq;
    logic [3:0]  irq;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  ext, d0, d1, d2, d3, d5, d8, e0, e1, e2, e3, e5, e8, u0, u1, u2, u3;
    logic [7:0]  l0, l1, l2, l3, l5, l7, l8, s8;
    logic [3:0]  s7;
    int          fails, comparisons, cyc;
    logic [15:0] dix[6] = '{PPC_IDX_P0_DIR, PPC_IDX_P1_DIR, PPC_IDX_P2_DIR,
                            PPC_IDX_P3_DIR, PPC_IDX_P5_DIR, PPC_IDX_P8_DIR};
    logic [15:0] pix[4] = '{PPC_IDX_P0_PUE, PPC_IDX_P1_PUE, PPC_IDX_P2_PUE, PPC_IDX_P3_PUE};
    logic [7:0]  dmk[6] = '{PPC_MASK_P0, PPC_MASK_P1, PPC_MASK_P2,
                            PPC_MASK_P3, PPC_MASK_P5, PPC_MASK_P8};

    ppc_top DUT (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(er), .i_p0_pin(l0), .i_p1_pin(l1), .i_p2_pin(l2),
        .i_p3_pin(l3), .i_p5_pin(l5), .i_p7_pin(l7[3:0]), .i_p8_pin(l8),
        .o_p0_pin(d0), .o_p0_oe(e0), .o_p1_pin(d1), .o_p1_oe(e1), .o_p2_pin(d2),
        .o_p2_oe(e2), .o_p3_pin(d3), .o_p3_oe(e3), .o_p5_pin(d5), .o_p5_oe(e5),
        .o_p8_pin(d8), .o_p8_oe(e8), .o_p0_pullup(u0), .o_p1_pullup(u1),
        .o_p2_pullup(u2), .o_p3_pullup(u3), .o_port7_segment_select(s7),
        .o_port8_segment_select(s8), .o_p3_irq_level(irq));
    // Board side of every port
    ppc_pin_model M0 (.i_ext(ext), .i_out(d0), .i_oe(e0), .i_pull(u0), .o_level(l0));
    ppc_pin_model M1 (.i_ext(ext), .i_out(d1), .i_oe(e1), .i_pull(u1), .o_level(l1));
    ppc_pin_model M2 (.i_ext(ext), .i_out(d2), .i_oe(e2), .i_pull(u2), .o_level(l2));
    ppc_pin_model M3 (.i_ext(ext), .i_out(d3), .i_oe(e3), .i_pull(u3), .o_level(l3));
    ppc_pin_model M5 (.i_ext(ext), .i_out(d5), .i_oe(e5), .i_pull(8'h00), .o_level(l5));
    ppc_pin_model M7 (.i_ext(ext), .i_out(8'h00), .i_oe(8'h00), .i_pull(8'h00), .o_level(l7));
    ppc_pin_model M8 (.i_ext(ext), .i_out(d8), .i_oe(e8), .i_pull(8'h00), .o_level(l8));

    // Clock and hang guard
    always #25 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            give_verdict();
        end
    end

    task give_verdict;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; outputs are looked at after the next falling edge
    task apb(input logic w, input logic [17:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        n = 0;
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            fails++;
        rd = prdata;
        erq = er;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask

    task wr(input logic [15:0] idx, input logic [31:0] wd);
        apb(1'b1, {idx, 2'h0}, wd);
    endtask

    task rdc(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, {idx, 2'h0}, 32'h0);
        chk(rd, exp);
    endtask

    task t_reset;
        for (int i = 0; i < 6; i++) rdc(dix[i], 32'hff);
        for (int i = 0; i < 4; i++) rdc(pix[i], 32'h00);
        rdc(PPC_IDX_P8_SEG, 32'h00);
        chk({e0, e8, u0, u3}, 32'h0);
        chk({28'h0, irq}, 32'h6);
    endtask

    task t_dir;
        for (int i = 0; i < 6; i++) wr(dix[i], 32'h00);
        for (int i = 0; i < 6; i++) rdc(dix[i], {24'h0, ~dmk[i]});
        chk({e0, e1, e2, e3}, 32'hff033f1f);
        chk({e5, e8}, 32'h0fff);
        chk({28'h0, irq}, 32'h0);
        for (int i = 0; i < 6; i++) wr(dix[i], 32'hff);
    endtask

    task t_bit;
        wr(PPC_IDX_P0_DIR, 32'h2300);
        rdc(PPC_IDX_P0_DIR, 32'hf7);
        chk(e0, 32'h08);
        wr(PPC_IDX_P0_DIR, 32'h1300);
        rdc(PPC_IDX_P0_DIR, 32'hff);
        wr(PPC_IDX_P1_PUE, 32'h1100);
        rdc(PPC_IDX_P1_PUE, 32'h02);
        wr(PPC_IDX_P1_PUE, 32'h2100);
        rdc(PPC_IDX_P1_PUE, 32'h00);
    endtask

    task t_pull;
        for (int i = 0; i < 4; i++) wr(pix[i], 32'hff);
        for (int i = 0; i < 4; i++) rdc(pix[i], {24'h0, dmk[i]});
        chk({u0, u1, u2, u3}, 32'hff033f1f);
        wr(PPC_IDX_P0_DIR, 32'h0f);
        chk(u0, 32'h0f);
        wr(PPC_IDX_P0_DIR, 32'hff);
        for (int i = 0; i < 4; i++) wr(pix[i], 32'h00);
    endtask

    task t_p8;
        wr(PPC_IDX_P8_DAT, 32'ha5);
        chk(e8, 32'h00);
        rdc(PPC_IDX_P8_DAT, 32'h96);
        wr(PPC_IDX_P8_DIR, 32'h00);
        chk({e8, d8}, 32'hffa5);
        rdc(PPC_IDX_P8_DAT, 32'ha5);
        wr(PPC_IDX_P8_SEG, 32'h0f);
        chk({s8, e8}, 32'h0ff0);
        rdc(PPC_IDX_P8_DAT, 32'ha0);
        wr(PPC_IDX_P8_SEG, 32'h00);
        wr(PPC_IDX_P8_DIR, 32'hff);
    endtask

    task t_p7;
        rdc(PPC_IDX_P7_DAT, 32'h06);
        wr(PPC_IDX_P7_SEG, 32'h03);
        chk(s7, 32'h3);
        rdc(PPC_IDX_P7_DAT, 32'h04);
        wr(PPC_IDX_P7_SEG, 32'h00);
    endtask

    task t_err;
        apb(1'b0, {16'hff10, 2'h0}, 32'h0);
        chk({31'h0, erq}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, {PPC_IDX_P0_DIR, 2'h1}, 32'h0);
        chk({31'h0, erq}, 32'h1);
        rdc(PPC_IDX_P0_DIR, 32'hff);
        apb(1'b0, {PPC_IDX_P0_DIR, 2'h1}, 32'h0);
        chk({31'h0, erq}, 32'h1);
        chk(rd, 32'h0);
    endtask

    // Timer output on port 3 bit 0, remote receive input on bit 4
    task t_alt;
        wr(PPC_IDX_P3_DAT, 32'h2000);
        wr(PPC_IDX_P3_DIR, 32'h2000);
        chk({e3, d3}, 32'h0100);
        wr(PPC_IDX_P3_DIR, 32'h1400);
        rdc(PPC_IDX_P3_DAT, 32'h16);
        chk({28'h0, irq}, 32'h6);
        wr(PPC_IDX_P3_DIR, 32'hff);
    endtask

    task t_rst2;
        wr(PPC_IDX_P0_DIR, 32'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(PPC_IDX_P0_DIR, 32'hff);
        chk(e0, 32'h00);
    endtask

    // Main sequence
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        ext = 8'h96;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_dir();
        t_bit();
        t_pull();
        t_p8();
        t_p7();
        t_alt();
        t_err();
        t_rst2();
        give_verdict();
    end
endmodule
